// File: inc/cmpvr_pkg.sv
// package: register map, field layout and ladder constants for the comparator sync and reference block
package cmpvr_pkg;

  // ==========================================================================
  // bus widths
  localparam int CMPVR_ADDR_W = 8;
  localparam int CMPVR_DATA_W = 32;
  localparam int CMPVR_REG_W = 8;

  // ==========================================================================
  // register byte addresses
  localparam logic [CMPVR_ADDR_W-1:0] CMPVR_SYNC_GATE_ADDR = 8'h00;
  localparam logic [CMPVR_ADDR_W-1:0] CMPVR_LADDER_ADDR = 8'h04;
  localparam logic [1:0] CMPVR_WORD_ALIGN = 2'h0;

  // ==========================================================================
  // field positions
  localparam int CMPVR_SYNC_BIT = 0;
  localparam int CMPVR_GATE_BIT = 1;
  localparam int CMPVR_REF_EN_BIT = 7;
  localparam int CMPVR_RANGE_BIT = 5;
  localparam int CMPVR_LEVEL_LSB = 0;
  localparam int CMPVR_LEVEL_W = 4;
  localparam int CMPVR_SELECT_W = CMPVR_LEVEL_W + 2;

  // ==========================================================================
  // reset values and implemented-bit masks
  localparam logic [CMPVR_REG_W-1:0] CMPVR_SYNC_GATE_RESET = 8'h02;
  localparam logic [CMPVR_REG_W-1:0] CMPVR_LADDER_RESET = 8'h00;
  localparam logic [CMPVR_REG_W-1:0] CMPVR_SYNC_GATE_MASK = 8'h03;
  localparam logic [CMPVR_REG_W-1:0] CMPVR_LADDER_MASK = 8'hAF;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] CMPVR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMPVR_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // ladder ratio, expressed in 96ths of the supply
  localparam int CMPVR_RATIO_W = 7;
  localparam int CMPVR_RATIO_SCALE = 96;
  localparam int CMPVR_LOW_DENOM = 24;
  localparam int CMPVR_HIGH_DENOM = 32;
  localparam int CMPVR_HIGH_BASE_DENOM = 4;
  localparam logic [CMPVR_RATIO_W-1:0] CMPVR_LOW_STEP = 7'(CMPVR_RATIO_SCALE / CMPVR_LOW_DENOM);
  localparam logic [CMPVR_RATIO_W-1:0] CMPVR_HIGH_STEP = 7'(CMPVR_RATIO_SCALE / CMPVR_HIGH_DENOM);
  localparam logic [CMPVR_RATIO_W-1:0] CMPVR_HIGH_BASE = 7'(CMPVR_RATIO_SCALE / CMPVR_HIGH_BASE_DENOM);
  localparam logic [CMPVR_RATIO_W-1:0] CMPVR_RATIO_GROUND = 7'h00;

  // ==========================================================================
  // bus channel states
  typedef enum logic {CMPVR_WR_IDLE, CMPVR_WR_RESP} cmpvr_wr_state_t;
  typedef enum logic {CMPVR_RD_IDLE, CMPVR_RD_DATA} cmpvr_rd_state_t;

  // tap ratio of an enabled ladder for a given range and level code
  function automatic logic [CMPVR_RATIO_W-1:0] cmpvr_tap_ratio(input logic low_range,
                                                               input logic [CMPVR_LEVEL_W-1:0] level);
    logic [CMPVR_RATIO_W-1:0] lvl;
    lvl = {3'h0, level};
    if (low_range) begin
      return 7'(lvl * CMPVR_LOW_STEP);
    end
    return 7'(CMPVR_HIGH_BASE + lvl * CMPVR_HIGH_STEP);
  endfunction

endpackage

// File: inc/cmpvr_cfg_if.sv
// interface: configuration fields carried from the register bank to the sync and ladder modules
`timescale 1ns/1ps
`default_nettype none
interface cmpvr_cfg_if;
  logic sync_enable;
  logic gate_select;
  logic ref_enable;
  logic ref_range;
  logic [cmpvr_pkg::CMPVR_LEVEL_W-1:0] ref_level;

  modport regs (output sync_enable, output gate_select, output ref_enable, output ref_range, output ref_level);
  modport sync_side (input sync_enable, input gate_select);
  modport ladder_side (input ref_enable, input ref_range, input ref_level);
endinterface
`default_nettype wire

// File: hdl/cmpvr_sync.sv
// module: comparator latch on the timer clock falling edge and gate source selection
`timescale 1ns/1ps
`default_nettype none
module cmpvr_sync
  import cmpvr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  cmpvr_cfg_if.sync_side cfg,
  // timer and comparator side
  input wire logic comp_out,
  input wire logic timer_clk_src,
  input wire logic timer_presc_clk,
  input wire logic timer_presc_on,
  input wire logic gate_pin,
  output logic gate_source,
  output logic synced_comp,
  output logic increment_strobe
);
  import cmpvr_pkg::*;

  logic sel_clk;
  logic prev_clk;
  logic fall_edge;
  logic comp_path;

  // the prescaler output replaces the raw source when the prescaler is in use
  assign sel_clk = timer_presc_on ? timer_presc_clk : timer_clk_src; // [R2]
  assign fall_edge = prev_clk & ~sel_clk;
  // counter advances on the rising edge, the latch on the falling one, so they never race
  assign increment_strobe = ~prev_clk & sel_clk; // [R3]

  // edge history of the selected timer clock
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_clk <= 1'b0;
    end else begin
      prev_clk <= sel_clk;
    end
  end

  // comparator latch, loaded only on the falling edge
  always_ff @(posedge clk) begin
    if (reset) begin
      synced_comp <= 1'b0;
    end else if (fall_edge) begin
      synced_comp <= comp_out; // [R1] [R3]
    end
  end

  // unlatched path when sync is off; pin or comparator picks the gate
  assign comp_path = cfg.sync_enable ? synced_comp : comp_out; // [R1]
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_source <= 1'b0;
    end else begin
      gate_source <= cfg.gate_select ? gate_pin : comp_path; // [R4]
    end
  end

  // ==========================================================================
  // checks
  fall_latch_a: assert property (@(posedge clk) disable iff (reset) // [R1]
    fall_edge |=> synced_comp == $past(comp_out)) else $error("comparator not latched on falling edge");
  latch_hold_a: assert property (@(posedge clk) disable iff (reset) // [R3]
    !fall_edge |=> $stable(synced_comp)) else $error("latch changed off the falling edge");
  presc_edge_a: assert property (@(posedge clk) disable iff (reset) // [R2]
    timer_presc_on && $past(timer_presc_on) && $fell(timer_presc_clk) |-> fall_edge)
    else $error("prescaled clock falling edge missed");
  gate_pin_a: assert property (@(posedge clk) disable iff (reset) // [R4]
    cfg.gate_select |=> gate_source == $past(gate_pin)) else $error("gate not taken from pin");
  gate_comp_a: assert property (@(posedge clk) disable iff (reset) // [R4]
    !cfg.gate_select && cfg.sync_enable |=> gate_source == $past(synced_comp))
    else $error("gate not taken from latched comparator");
  async_path_a: assert property (@(posedge clk) disable iff (reset) // [R1]
    !cfg.gate_select && !cfg.sync_enable |=> gate_source == $past(comp_out))
    else $error("unlatched comparator path broken");
  sync_gate_c: cover property (@(posedge clk) disable iff (reset)
    !cfg.gate_select && cfg.sync_enable && fall_edge ##1 gate_source);
endmodule
`default_nettype wire

// File: hdl/cmpvr_ladder.sv
// module: reference ladder selection bus and tap ratio
`timescale 1ns/1ps
`default_nettype none
module cmpvr_ladder
  import cmpvr_pkg::*;
(
  // clock and reset, used by the checks
  input wire logic clk,
  input wire logic reset,
  // configuration
  cmpvr_cfg_if.ladder_side cfg,
  // analog ladder side
  output logic [cmpvr_pkg::CMPVR_SELECT_W-1:0] ladder_select,
  output logic power_enable,
  output logic [cmpvr_pkg::CMPVR_RATIO_W-1:0] tap_ratio
);
  import cmpvr_pkg::*;

  // no comparator mode enters here, so nothing can override the settings
  assign ladder_select = {cfg.ref_enable, cfg.ref_range, cfg.ref_level}; // [R15] [R13]
  assign power_enable = cfg.ref_enable; // [R6]

  // ground when disabled, else the tap of the chosen range
  always_comb begin
    if (!cfg.ref_enable) begin
      tap_ratio = CMPVR_RATIO_GROUND; // [R7]
    end else begin
      tap_ratio = cmpvr_tap_ratio(cfg.ref_range, cfg.ref_level); // [R8] [R9] [R10] [R11]
    end
  end

  // ==========================================================================
  // checks
  ground_off_a: assert property (@(posedge clk) disable iff (reset) // [R7]
    !power_enable |-> tap_ratio == CMPVR_RATIO_GROUND) else $error("disabled ladder not at ground");
  low_range_a: assert property (@(posedge clk) disable iff (reset) // [R10]
    cfg.ref_enable && cfg.ref_range |-> tap_ratio == 7'({3'h0, cfg.ref_level} * 7'h04))
    else $error("low range tap wrong");
  high_range_a: assert property (@(posedge clk) disable iff (reset) // [R11]
    cfg.ref_enable && !cfg.ref_range |-> tap_ratio == 7'(7'h18 + {3'h0, cfg.ref_level} * 7'h03))
    else $error("high range tap wrong");
  top_tap_c: cover property (@(posedge clk) disable iff (reset) power_enable && cfg.ref_level == 4'hF);
endmodule
`default_nettype wire

// File: hdl/cmpvr_top.sv
// module: register bank on an AXI4-Lite slave, driving comparator sync and reference ladder
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - sync bit latches comparator on falling edge
// R2 - prescaler output clocks the latch
// R3 - latch falling edge, counter rising edge
// R4 - gate select: pin or comparator path
// R5 - unused bits read zero, ignore writes
// R6 - enable bit powers the ladder
// R7 - disabled ladder forces ground output
// R8 - range bit: one low, zero high
// R9 - four-bit level picks one of sixteen
// R10 - low range is level over 24
// R11 - high range quarter plus level/32
// R12 - software grounds reference by clearing fields
// R13 - settings independent of comparator mode
// R14 - software should sync when comparator gates
// R15 - selection bus follows register same cycle
// R16 - reset: gate from pin, ladder zero
module cmpvr_top
  import cmpvr_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [cmpvr_pkg::CMPVR_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [cmpvr_pkg::CMPVR_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [cmpvr_pkg::CMPVR_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [cmpvr_pkg::CMPVR_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // comparator and timer side
  input wire logic SECOND_COMPARATOR_OUT,
  input wire logic TIMER_CLOCK_SOURCE,
  input wire logic TIMER_PRESCALED_CLOCK,
  input wire logic TIMER_PRESCALER_ON,
  input wire logic EXTERNAL_GATE_PIN,
  output logic TIMER_GATE_SOURCE,
  output logic SYNCED_COMPARATOR_OUT,
  output logic TIMER_INCREMENT_STROBE,
  // reference ladder side
  output logic [cmpvr_pkg::CMPVR_SELECT_W-1:0] LADDER_SELECT,
  output logic LADDER_POWER_ENABLE,
  output logic [cmpvr_pkg::CMPVR_RATIO_W-1:0] INTERNAL_REFERENCE_OUTPUT
);
  import cmpvr_pkg::*;

  // ==========================================================================
  // decoding shared by both channels
  function automatic logic cmpvr_is_reg(input logic [CMPVR_ADDR_W-1:0] addr,
                                        input logic [CMPVR_ADDR_W-1:0] reg_addr);
    return addr[CMPVR_ADDR_W-1:2] == reg_addr[CMPVR_ADDR_W-1:2];
  endfunction

  function automatic logic cmpvr_mapped(input logic [CMPVR_ADDR_W-1:0] addr);
    return cmpvr_is_reg(addr, CMPVR_SYNC_GATE_ADDR) || cmpvr_is_reg(addr, CMPVR_LADDER_ADDR);
  endfunction

  // ==========================================================================
  // registers and channel state
  logic [CMPVR_REG_W-1:0] comparator_sync_gate_select;
  logic [CMPVR_REG_W-1:0] reference_ladder_control;
  cmpvr_wr_state_t wr_state;
  cmpvr_rd_state_t rd_state;
  logic aw_held;
  logic w_held;
  logic [CMPVR_ADDR_W-1:0] aw_addr;
  logic [CMPVR_REG_W-1:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic [CMPVR_REG_W-1:0] next_read_byte;

  // ==========================================================================
  // write channel
  // address and data are taken in either order; each ready drops once its item is held
  assign S_AXI_AWREADY = !aw_held && wr_state == CMPVR_WR_IDLE;
  assign S_AXI_WREADY = !w_held && wr_state == CMPVR_WR_IDLE;
  assign do_write = aw_held && w_held && wr_state == CMPVR_WR_IDLE;

  // capture of the write address
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // capture of the write data; only byte lane 0 holds register bits
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      w_held <= 1'b0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_byte <= S_AXI_WDATA[CMPVR_REG_W-1:0];
      w_lane0 <= S_AXI_WSTRB[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      wr_state <= CMPVR_WR_IDLE;
      S_AXI_BRESP <= CMPVR_RESP_OKAY;
    end else begin
      unique case (wr_state)
        CMPVR_WR_IDLE: begin
          if (do_write) begin
            wr_state <= CMPVR_WR_RESP;
            S_AXI_BRESP <= cmpvr_mapped(aw_addr) ? CMPVR_RESP_OKAY : CMPVR_RESP_SLVERR;
          end
        end
        CMPVR_WR_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state <= CMPVR_WR_IDLE;
          end
        end
      endcase
    end
  end
  assign S_AXI_BVALID = wr_state == CMPVR_WR_RESP;

  // ==========================================================================
  // register bank
  // unused bits are masked on write, so they stay zero and read back as zero
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      comparator_sync_gate_select <= CMPVR_SYNC_GATE_RESET; // [R16]
    end else if (do_write && w_lane0 && cmpvr_is_reg(aw_addr, CMPVR_SYNC_GATE_ADDR)) begin
      comparator_sync_gate_select <= w_byte & CMPVR_SYNC_GATE_MASK; // [R5]
    end
  end

  // ladder control; any value of the level field is accepted
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      reference_ladder_control <= CMPVR_LADDER_RESET; // [R16]
    end else if (do_write && w_lane0 && cmpvr_is_reg(aw_addr, CMPVR_LADDER_ADDR)) begin
      reference_ladder_control <= w_byte & CMPVR_LADDER_MASK; // [R5] [R9]
    end
  end

  // ==========================================================================
  // read channel
  assign S_AXI_ARREADY = rd_state == CMPVR_RD_IDLE;

  // read data selection; unmapped words read as zero
  always_comb begin
    next_read_byte = '0;
    if (cmpvr_is_reg(S_AXI_ARADDR, CMPVR_SYNC_GATE_ADDR)) begin
      next_read_byte = comparator_sync_gate_select;
    end else if (cmpvr_is_reg(S_AXI_ARADDR, CMPVR_LADDER_ADDR)) begin
      next_read_byte = reference_ladder_control;
    end
  end

  // read answer, one cycle after the address is taken
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rd_state <= CMPVR_RD_IDLE;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= CMPVR_RESP_OKAY;
    end else begin
      unique case (rd_state)
        CMPVR_RD_IDLE: begin
          if (S_AXI_ARVALID) begin
            rd_state <= CMPVR_RD_DATA;
            S_AXI_RDATA <= {{(CMPVR_DATA_W-CMPVR_REG_W){1'b0}}, next_read_byte};
            S_AXI_RRESP <= cmpvr_mapped(S_AXI_ARADDR) ? CMPVR_RESP_OKAY : CMPVR_RESP_SLVERR;
          end
        end
        CMPVR_RD_DATA: begin
          if (S_AXI_RREADY) begin
            rd_state <= CMPVR_RD_IDLE;
          end
        end
      endcase
    end
  end
  assign S_AXI_RVALID = rd_state == CMPVR_RD_DATA;

  // ==========================================================================
  // configuration fanout
  cmpvr_cfg_if cfg ();

  // fields leave the register bank without any comparator mode term in between
  assign cfg.sync_enable = comparator_sync_gate_select[CMPVR_SYNC_BIT];
  assign cfg.gate_select = comparator_sync_gate_select[CMPVR_GATE_BIT];
  assign cfg.ref_enable = reference_ladder_control[CMPVR_REF_EN_BIT]; // [R6] [R13]
  assign cfg.ref_range = reference_ladder_control[CMPVR_RANGE_BIT]; // [R8]
  assign cfg.ref_level = reference_ladder_control[CMPVR_LEVEL_LSB +: CMPVR_LEVEL_W];

  // comparator latch and gate source
  cmpvr_sync u_sync (
    .clk(CLK_SYS),
    .reset(RESET),
    .cfg(cfg.sync_side),
    .comp_out(SECOND_COMPARATOR_OUT),
    .timer_clk_src(TIMER_CLOCK_SOURCE),
    .timer_presc_clk(TIMER_PRESCALED_CLOCK),
    .timer_presc_on(TIMER_PRESCALER_ON),
    .gate_pin(EXTERNAL_GATE_PIN),
    .gate_source(TIMER_GATE_SOURCE),
    .synced_comp(SYNCED_COMPARATOR_OUT),
    .increment_strobe(TIMER_INCREMENT_STROBE)
  );

  // reference ladder controls
  cmpvr_ladder u_ladder (
    .clk(CLK_SYS),
    .reset(RESET),
    .cfg(cfg.ladder_side),
    .ladder_select(LADDER_SELECT),
    .power_enable(LADDER_POWER_ENABLE),
    .tap_ratio(INTERNAL_REFERENCE_OUTPUT)
  );

  // ==========================================================================
  // checks
  reset_values_a: assert property (@(posedge CLK_SYS) // [R16]
    RESET |=> comparator_sync_gate_select == 8'h02 && reference_ladder_control == 8'h00
      && !LADDER_POWER_ENABLE) else $error("registers not at reset values");
  reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R5]
    (comparator_sync_gate_select & ~8'h03) == 8'h00 && (reference_ladder_control & ~8'hAF) == 8'h00)
    else $error("unused register bit set");
  ladder_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R15]
    do_write && w_lane0 && aw_addr[CMPVR_ADDR_W-1:2] == 6'h01
      |=> LADDER_SELECT == {$past(w_byte[7]), $past(w_byte[5]), $past(w_byte[3:0])})
    else $error("ladder bus did not follow write");
  write_resp_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    do_write |=> S_AXI_BVALID ##0 !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write response not raised after write");
  read_answer_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // [R5]
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[CMPVR_ADDR_W-1:2] == 6'h00
      |=> S_AXI_RVALID && S_AXI_RDATA[31:2] == 30'h0) else $error("read of sync register wrong");
  read_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before taken");
  // a second request while an answer is pending would be lost
  write_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write taken while response pending");
  read_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while answer pending");
  bad_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    S_AXI_ARVALID && S_AXI_ARREADY && !cmpvr_mapped(S_AXI_ARADDR)
      |=> S_AXI_RRESP == CMPVR_RESP_SLVERR && S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  sync_write_c: cover property (@(posedge CLK_SYS) disable iff (RESET)
    do_write && aw_addr == CMPVR_SYNC_GATE_ADDR ##1 S_AXI_BVALID);
  bad_read_c: cover property (@(posedge CLK_SYS) disable iff (RESET)
    S_AXI_RVALID && S_AXI_RRESP == CMPVR_RESP_SLVERR);
endmodule
`default_nettype wire

// File: bench/cmpvr_timer_model.sv
// partner model: timer clock source, prescaler output and gated counter
`timescale 1ns/1ps
`default_nettype none
module cmpvr_timer_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // gate and increment from the block
  input wire logic gate,
  input wire logic strobe,
  // timer clocks towards the block
  output logic timer_src,
  output logic presc_clk,
  output logic [15:0] count
);
  logic [1:0] div;
  // source toggles every third system cycle; prescaler halves it on each source fall
  always_ff @(posedge clk) begin
    if (reset) begin
      div <= 2'h0;
      timer_src <= 1'b0;
      presc_clk <= 1'b0;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) begin
        timer_src <= !timer_src;
        if (timer_src) presc_clk <= !presc_clk;
      end
    end
  end
  // counter advances on increment strobes only while the gate is open
  always_ff @(posedge clk) begin
    if (reset) count <= 16'h0000;
    else if (strobe && gate) count <= count + 16'h0001;
  end
endmodule
`default_nettype wire

// File: bench/test_comparator_sync_and_vref_control.sv
// testbench: register bus, reference ladder and comparator sync checks
`timescale 1ns/1ps
`default_nettype none
module test_comparator_sync_and_vref_control;
  import cmpvr_pkg::*;
  // ==========================================================================
  // stimulus and observation
  logic clk_sys = 1'b0, reset = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cfg = 8'h02, v;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic comp = 1'b0, pin = 1'b0, presc_on = 1'b0, mon_on = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, gate, synced, strobe, power, tsrc, pclk, sel_clk;
  logic h, exp_sync, exp_gate;
  logic [1:0] bresp, rresp;
  logic [5:0] sel;
  logic [6:0] ratio, er;
  logic [15:0] tcount;
  int fail_count = 0, total_checks = 0, seed = 80;
  logic [1:0] wq[$];
  logic [33:0] rq[$];

  always #5 clk_sys = !clk_sys;
  assign sel_clk = presc_on ? pclk : tsrc;

  cmpvr_top DUT (.CLK_SYS(clk_sys), .RESET(reset),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .SECOND_COMPARATOR_OUT(comp), .TIMER_CLOCK_SOURCE(tsrc), .TIMER_PRESCALED_CLOCK(pclk),
    .TIMER_PRESCALER_ON(presc_on), .EXTERNAL_GATE_PIN(pin), .TIMER_GATE_SOURCE(gate),
    .SYNCED_COMPARATOR_OUT(synced), .TIMER_INCREMENT_STROBE(strobe),
    .LADDER_SELECT(sel), .LADDER_POWER_ENABLE(power), .INTERNAL_REFERENCE_OUTPUT(ratio));

  cmpvr_timer_model timer (.clk(clk_sys), .reset(reset), .gate(gate), .strobe(strobe),
    .timer_src(tsrc), .presc_clk(pclk), .count(tcount));

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data are offered together and each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] e);
    logic aw_done, w_done;
    logic [31:0] r;
    aw_done = 1'b0;
    w_done = 1'b0;
    r = $random(seed);
    @(posedge clk_sys);
    wq.push_back(e);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {r[31:8], d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk_sys);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // result watcher: bus answers against queued notes, timer side against a tracked copy
  always @(posedge clk_sys) begin
    if (bvalid && bready) chk(34'(bresp), 34'(wq.pop_front()));
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    comp <= 1'($random(seed));
    pin <= 1'($random(seed));
    if (reset) begin
      h <= 1'b0;
      exp_sync <= 1'b0;
    end else begin
      h <= sel_clk;
      if (h && !sel_clk) exp_sync <= comp;
      exp_gate <= cfg[1] ? pin : (cfg[0] ? exp_sync : comp);
    end
  end

  // outputs are settled by the falling edge
  always @(negedge clk_sys) begin
    if (mon_on) begin
      chk(34'(gate), 34'(exp_gate));
      chk(34'(strobe), 34'(sel_clk && !h));
      if (cfg[0]) chk(34'(synced), 34'(exp_sync));
    end
  end

  // a hang is cut short well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h00, 34'h002);
    rd(8'h04, 34'h000);
    $display("reset values test done");
    wr(8'h00, 8'hFF, 4'hF, 2'h0);
    rd(8'h00, 34'h003);
    wr(8'h00, 8'h00, 4'h0, 2'h0);
    rd(8'h00, 34'h003);
    wr(8'h08, 8'hFF, 4'hF, 2'h2);
    rd(8'h08, {2'h2, 32'h0});
    $display("register access test done");
    // every range and level, enabled and not; i=0 is the grounded idle setting
    for (int i = 0; i < 64; i++) begin
      v = 8'($random(seed));
      v[7] = i[5];
      v[5] = i[4];
      v[3:0] = i[3:0];
      wr(8'h04, v, 4'hF, 2'h0);
      er = !v[7] ? 7'h00 : (v[5] ? 7'(v[3:0] * (96 / 24)) : 7'(96 / 4 + v[3:0] * (96 / 32)));
      chk(34'(sel), 34'({v[7], v[5], v[3:0]}));
      chk(34'(power), 34'(v[7]));
      chk(34'(ratio), 34'(er));
      rd(8'h04, 34'(v & 8'hAF));
    end
    $display("reference ladder test done");
    // gate and sync modes with and without prescaler; mode 1 syncs when gating
    for (int m = 0; m < 8; m++) begin
      presc_on <= m[2];
      wr(8'h00, 8'hFC | 8'(m[1:0]), 4'h1, 2'h0);
      cfg = 8'(m[1:0]);
      repeat (14) @(posedge clk_sys);
      mon_on <= 1'b1;
      repeat (40) @(posedge clk_sys);
      mon_on <= 1'b0;
    end
    $display("timer gate test done");
    reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    cfg = 8'h02;
    rd(8'h00, 34'h002);
    rd(8'h04, 34'h000);
    chk(34'(power), 34'h0);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
